// file: hw/clk_chan_defs.vh
`ifndef CLK_CHAN_DEFS_VH
`define CLK_CHAN_DEFS_VH

`define NUM_CHAN 5
// register byte offsets
`define OFF_DIV0 12'h000
`define OFF_DLY0 12'h020
`define OFF_REFSEL 12'h040
`define OFF_STATUS 12'h044
`define OFF_MASK 12'h048
`define OFF_ENABLE 12'h04C
// channel divide field: ratio = 2*value, zero means bypass (divide by two, same as value 1)
`define DIV_W 8
`define DIV_RST 8'h00
`define DIV_BYPASS 8'h00
// delay field: unsigned step count
`define DLY_W 4
`define DLY_RST 4'h0
`define DLY_STEP_PS 150
`define DLY_MAX_PS 2250
// reference select modes
`define REF_FIX0 2'h0
`define REF_FIX1 2'h1
`define REF_AUTO_A 2'h2
`define REF_AUTO_B 2'h3
// loss indicator drive types
`define LOS_PUSHPULL 2'h0
`define LOS_NMOS_OD 2'h1
`define LOS_PMOS_OD 2'h2
// reference select register fields
`define REFSEL_MODE_LSB 0
`define REFSEL_DRV_LSB 4
`define REFSEL_RST 8'h00
// status bits
`define ST_LOS0 0
`define ST_LOS1 1
`define ST_SWITCH 2
// pclk cycles without a reference edge that count as loss
`define LOS_TIMEOUT 8'h40

`endif

// file: hw/chan_divider.v
`include "clk_chan_defs.vh"

module chan_divider (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire dist_tick, // distribution clock enable pulse
  input wire [`DIV_W-1:0] channel_divide_value, // ratio is twice this, zero bypasses
  input wire [`DLY_W-1:0] channel_delay_setting, // delay steps
  input wire run, // channel enabled
  output reg clk_out, // divided clock level
  output reg [`DLY_W-1:0] delay_steps, // applied delay step count
  output reg [11:0] delay_ps // realized delay in ps
);
  reg [`DIV_W-1:0] cnt_r;
  reg [`DIV_W-1:0] cnt_nxt;
  reg clk_nxt;

  always @* begin
    cnt_nxt = cnt_r;
    clk_nxt = clk_out;
    if (!run) begin
      cnt_nxt = {`DIV_W{1'b0}};
      clk_nxt = 1'b0;
    end else if (dist_tick) begin
      // RQ3 bypass toggles every tick, divide by two
      if (channel_divide_value == `DIV_BYPASS) begin
        clk_nxt = ~clk_out;
      // RQ2 even ratio divide
      end else if (cnt_r + 8'h01 >= channel_divide_value) begin
        cnt_nxt = {`DIV_W{1'b0}};
        clk_nxt = ~clk_out;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {`DIV_W{1'b0}};
      clk_out <= 1'b0;
      delay_steps <= `DLY_RST;
      delay_ps <= 12'h000;
    end else begin
      cnt_r <= cnt_nxt;
      clk_out <= clk_nxt;
      // RQ8 delay count times step
      delay_steps <= channel_delay_setting;
      delay_ps <= channel_delay_setting * 12'd150;
    end
  end
endmodule // chan_divider

// file: hw/clock_channel_ctrl.v
// Register access over APB and the register addresses were chosen for this implementation.
`include "clk_chan_defs.vh"

// Overview of operation
// RQ1: five channels each own an independently programmed output divider
// RQ2: divider uses even ratios 2 to 510 in steps of 2
// RQ3: bypass setting passes the distribution clock undivided; bypass here divides by two, as value 1 does
// RQ4: each channel delay in 150 ps steps, 0 to 2250 ps
// RQ5: reference fixed to input zero or one, or two automatic modes
// RQ6: in automatic modes, loss flag shows selected input signal status
// RQ7: loss outputs are push-pull active high, or NMOS or PMOS open drain
// RQ8: delay is a step count 0..15 times the step size
module clock_channel_ctrl (
  input wire pclk, // system clock 100 MHz
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error
  input wire dist_tick, // distribution clock enable pulse
  input wire reference_input_zero, // reference 0 sampled level
  input wire reference_input_one, // reference 1 sampled level
  output wire [4:0] clk_out, // channel clocks
  output wire [19:0] delay_steps, // channel delay steps, 4 bits each
  output reg ref_select_one, // selected reference is input one
  output reg reference_loss_flag_zero_o, // loss 0 output drive value
  output reg reference_loss_flag_zero_oe, // loss 0 output enable
  output reg reference_loss_flag_one_o, // loss 1 output drive value
  output reg reference_loss_flag_one_oe, // loss 1 output enable
  output wire irq // level interrupt
);
  reg [`DIV_W-1:0] div_r [0:`NUM_CHAN-1];
  reg [`DLY_W-1:0] dly_r [0:`NUM_CHAN-1];
  reg [7:0] refsel_r;
  reg [2:0] status_r;
  reg [2:0] mask_r;
  reg [4:0] enable_r;
  reg [7:0] los_cnt0_r;
  reg [7:0] los_cnt1_r;
  reg ref0_d_r;
  reg ref1_d_r;
  reg lost0_r;
  reg lost1_r;
  wire [1:0] mode = refsel_r[`REFSEL_MODE_LSB +: 2];
  wire [1:0] drv = refsel_r[`REFSEL_DRV_LSB +: 2];
  wire auto_mode = mode[1];
  wire wr = psel & penable & pwrite;
  // read data captured at the setup edge so it stands through the access cycle
  wire rd_en = psel & ~penable & ~pwrite;
  reg hit;
  integer i;

  // index of a per-channel register, or 7 if not one
  function [2:0] chan_idx;
    input [11:0] a;
    input [11:0] base;
    reg [11:0] off;
    begin
      off = a - base;
      if (a >= base && a < base + 12'h014 && a[1:0] == 2'b00)
        chan_idx = off[4:2];
      else
        chan_idx = 3'h7;
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign irq = |(status_r & mask_r);

  genvar g;
  generate
    for (g = 0; g < `NUM_CHAN; g = g + 1) begin : chan
      // RQ1 one divider each
      chan_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .dist_tick(dist_tick),
        .channel_divide_value(div_r[g]),
        .channel_delay_setting(dly_r[g]),
        .run(enable_r[g]),
        .clk_out(clk_out[g]),
        .delay_steps(delay_steps[g*4 +: 4]),
        .delay_ps()
      );
    end
  endgenerate

  always @* begin
    hit = 1'b1;
    if (chan_idx(paddr, `OFF_DIV0) == 3'h7 && chan_idx(paddr, `OFF_DLY0) == 3'h7 &&
        paddr != `OFF_REFSEL && paddr != `OFF_STATUS && paddr != `OFF_MASK &&
        paddr != `OFF_ENABLE)
      hit = 1'b0;
  end

  // loss detection: no edge within timeout
  wire edge0 = reference_input_zero ^ ref0_d_r;
  wire edge1 = reference_input_one ^ ref1_d_r;
  wire lost0_nxt = ~edge0 & (los_cnt0_r >= `LOS_TIMEOUT - 8'h01);
  wire lost1_nxt = ~edge1 & (los_cnt1_r >= `LOS_TIMEOUT - 8'h01);
  reg sel_nxt;

  // RQ5 reference select mode
  always @* begin
    case (mode)
      `REF_FIX0: sel_nxt = 1'b0;
      `REF_FIX1: sel_nxt = 1'b1;
      // mode a: switch on loss and stay (non-revertive)
      `REF_AUTO_A: sel_nxt = ref_select_one ? ~(lost1_r & ~lost0_r) : (lost0_r & ~lost1_r);
      // mode b: prefer input zero whenever it is present
      `REF_AUTO_B: sel_nxt = lost0_r & ~lost1_r;
      default: sel_nxt = 1'b0;
    endcase
  end

  wire sel_lost = ref_select_one ? lost1_r : lost0_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `NUM_CHAN; i = i + 1) begin
        div_r[i] <= `DIV_RST;
        dly_r[i] <= `DLY_RST;
      end
      refsel_r <= `REFSEL_RST;
      status_r <= 3'h0;
      mask_r <= 3'h0;
      enable_r <= 5'h00;
      prdata <= 32'h00000000;
      los_cnt0_r <= 8'h00;
      los_cnt1_r <= 8'h00;
      ref0_d_r <= 1'b0;
      ref1_d_r <= 1'b0;
      lost0_r <= 1'b0;
      lost1_r <= 1'b0;
      ref_select_one <= 1'b0;
    end else begin
      ref0_d_r <= reference_input_zero;
      ref1_d_r <= reference_input_one;
      los_cnt0_r <= edge0 ? 8'h00 : (lost0_nxt ? los_cnt0_r : los_cnt0_r + 8'h01);
      los_cnt1_r <= edge1 ? 8'h00 : (lost1_nxt ? los_cnt1_r : los_cnt1_r + 8'h01);
      lost0_r <= lost0_nxt;
      lost1_r <= lost1_nxt;
      ref_select_one <= sel_nxt;
      if (wr) begin
        if (chan_idx(paddr, `OFF_DIV0) != 3'h7)
          div_r[chan_idx(paddr, `OFF_DIV0)] <= pwdata[`DIV_W-1:0];
        // RQ4 delay step register
        if (chan_idx(paddr, `OFF_DLY0) != 3'h7)
          dly_r[chan_idx(paddr, `OFF_DLY0)] <= pwdata[`DLY_W-1:0];
        if (paddr == `OFF_REFSEL)
          refsel_r <= pwdata[7:0] & 8'h33;
        if (paddr == `OFF_MASK)
          mask_r <= pwdata[2:0];
        if (paddr == `OFF_ENABLE)
          enable_r <= pwdata[4:0];
      end
      // set wins over write-one clear
      status_r <= (status_r & ~((wr && paddr == `OFF_STATUS) ? pwdata[2:0] : 3'h0)) |
        {ref_select_one ^ sel_nxt, lost1_nxt & ~lost1_r & auto_mode,
         lost0_nxt & ~lost0_r & auto_mode};
      if (rd_en) begin
        prdata <= 32'h00000000;
        if (chan_idx(paddr, `OFF_DIV0) != 3'h7)
          prdata[`DIV_W-1:0] <= div_r[chan_idx(paddr, `OFF_DIV0)];
        if (chan_idx(paddr, `OFF_DLY0) != 3'h7)
          prdata[`DLY_W-1:0] <= dly_r[chan_idx(paddr, `OFF_DLY0)];
        if (paddr == `OFF_REFSEL)
          prdata <= {16'h0000, 5'h00, lost1_r, lost0_r, ref_select_one, refsel_r};
        if (paddr == `OFF_STATUS)
          prdata[2:0] <= status_r;
        if (paddr == `OFF_MASK)
          prdata[2:0] <= mask_r;
        if (paddr == `OFF_ENABLE)
          prdata[4:0] <= enable_r;
      end
    end
  end

  // RQ6 report selected input loss
  // RQ7 loss output drive type
  always @* begin
    reference_loss_flag_zero_o = 1'b0;
    reference_loss_flag_zero_oe = 1'b0;
    reference_loss_flag_one_o = 1'b0;
    reference_loss_flag_one_oe = 1'b0;
    if (auto_mode) begin
      case (drv)
        `LOS_PUSHPULL: begin
          reference_loss_flag_zero_oe = 1'b1;
          reference_loss_flag_one_oe = 1'b1;
          reference_loss_flag_zero_o = ~ref_select_one & sel_lost;
          reference_loss_flag_one_o = ref_select_one & sel_lost;
        end
        `LOS_NMOS_OD: begin
          reference_loss_flag_zero_oe = ~ref_select_one & sel_lost;
          reference_loss_flag_one_oe = ref_select_one & sel_lost;
        end
        `LOS_PMOS_OD: begin
          reference_loss_flag_zero_o = 1'b1;
          reference_loss_flag_one_o = 1'b1;
          reference_loss_flag_zero_oe = ~ref_select_one & sel_lost;
          reference_loss_flag_one_oe = ref_select_one & sel_lost;
        end
        default: begin
          reference_loss_flag_zero_oe = 1'b0;
        end
      endcase
    end
  end
endmodule // clock_channel_ctrl

// file: tb/ref_clock_model.sv
module ref_clock_model (
  input wire pclk, // system clock
  input wire stop0, // halt reference zero
  input wire stop1, // halt reference one
  output logic ref0, // reference zero level
  output logic ref1, // reference one level
  output logic tick // distribution tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph = 2'h0;
  initial begin
    ref0 = 1'b0;
    ref1 = 1'b0;
    tick = 1'b0;
  end
  // a lost source freezes, so the detector sees no edges
  always @(posedge pclk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    tick <= ~tick;
    if (ph == 2'h0 && !stop0) ref0 <= ~ref0;
    if (ph == 2'h1 && !stop1) ref1 <= ~ref1;
  end
endmodule // ref_clock_model

// file: tb/clock_channel_ctrl_assertions.sv
`include "clk_chan_defs.vh"
module clock_channel_checker (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb address
  input wire [31:0] pwdata, // apb write data
  input wire pready, // apb ready
  input wire pslverr, // apb error
  input wire dist_tick, // distribution tick
  input wire [4:0] clk_out, // channel clocks
  input wire [19:0] delay_steps, // delay steps
  input wire ref_select_one, // input one selected
  input wire reference_loss_flag_zero_o, // loss 0 value
  input wire reference_loss_flag_zero_oe, // loss 0 enable
  input wire reference_loss_flag_one_oe // loss 1 enable
);
  reg [7:0] div0_r;
  reg [3:0] dly0_r;
  reg [5:0] sel_r;
  reg [4:0] en_r;
  reg [1:0] age_r;
  wire wr = psel && penable && pwrite && pready;
  // settled: no write for three cycles, so registered outputs caught up
  wire calm = (age_r == 2'h3) && !wr;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div0_r <= 8'h00;
      dly0_r <= 4'h0;
      sel_r <= 6'h00;
      en_r <= 5'h00;
      age_r <= 2'h0;
    end else begin
      age_r <= wr ? 2'h0 : ((age_r == 2'h3) ? age_r : age_r + 2'h1);
      if (wr && paddr == `OFF_DIV0) div0_r <= pwdata[7:0];
      if (wr && paddr == `OFF_DLY0) dly0_r <= pwdata[3:0];
      if (wr && paddr == `OFF_REFSEL) sel_r <= pwdata[5:0];
      if (wr && paddr == `OFF_ENABLE) en_r <= pwdata[4:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pready_high: assert property (pready) else $error("pready low");
  chk_err_phase: assert property (pslverr |-> psel && penable) else $error("pslverr out of phase");
  chk_bypass_tick: assert property (calm && en_r[0] && div0_r == `DIV_BYPASS && dist_tick
    |=> clk_out[0] != $past(clk_out[0])) else $error("bypass missed a tick");
  chk_hold_notick: assert property (calm && !dist_tick |=> $stable(clk_out[0]))
    else $error("channel moved without tick");
  chk_idle_low: assert property (calm && !en_r[2] |-> !clk_out[2])
    else $error("disabled channel not low");
  chk_delay_follow: assert property (calm |-> delay_steps[3:0] == dly0_r)
    else $error("delay steps differ");
  chk_fixed_sel: assert property (calm && !sel_r[1] |-> ref_select_one == sel_r[0])
    else $error("fixed selection wrong");
  chk_flag_fixed: assert property (calm && !sel_r[1]
    |-> !reference_loss_flag_zero_oe && !reference_loss_flag_one_oe)
    else $error("loss flag driven in fixed mode");
  chk_nmos_low: assert property (calm && sel_r[5:4] == `LOS_NMOS_OD && reference_loss_flag_zero_oe
    |-> !reference_loss_flag_zero_o) else $error("open drain drives high");
endmodule // clock_channel_checker
bind clock_channel_ctrl clock_channel_checker i_clock_channel_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .dist_tick(dist_tick),
  .clk_out(clk_out), .delay_steps(delay_steps), .ref_select_one(ref_select_one),
  .reference_loss_flag_zero_o(reference_loss_flag_zero_o),
  .reference_loss_flag_zero_oe(reference_loss_flag_zero_oe),
  .reference_loss_flag_one_oe(reference_loss_flag_one_oe));

// file: tb/tb_top.sv
`include "clk_chan_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stop0 = 0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, q;
  wire [31:0] prdata;
  wire pready, pslverr, dist_tick, r0, r1, irq, sel1, z_o, z_oe, o_o, o_oe;
  wire [4:0] clk_out;
  wire [19:0] delay_steps;
  int errors = 0, checked = 0, n, ticks = 0;
  int vals[5] = '{0, 1, 2, 255, 7};
  clock_channel_ctrl i_clock_channel_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dist_tick(dist_tick), .reference_input_zero(r0),
    .reference_input_one(r1), .clk_out(clk_out), .delay_steps(delay_steps),
    .ref_select_one(sel1), .reference_loss_flag_zero_o(z_o),
    .reference_loss_flag_zero_oe(z_oe), .reference_loss_flag_one_o(o_o),
    .reference_loss_flag_one_oe(o_oe), .irq(irq));
  ref_clock_model i_ref_clock_model (.pclk(pclk), .stop0(stop0), .stop1(1'b0), .ref0(r0),
    .ref1(r1), .tick(dist_tick));
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) if (dist_tick === 1'b1) ticks <= ticks + 1;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // read data and error taken at the access edge where pready is high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic period(input int g, output int p);
    logic prev;
    int t0, k;
    prev = clk_out[g];
    t0 = -1;
    p = 0;
    for (k = 0; k < 3000 && p == 0; k++) begin
      @(posedge pclk);
      #1;
      if (clk_out[g] === 1'b1 && prev === 1'b0) begin
        if (t0 >= 0) p = ticks - t0;
        else t0 = ticks;
      end
      prev = clk_out[g];
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    xfer(0, `OFF_DIV0, 0, q, e);
    check("div0 reset", q, 0);
    xfer(0, 12'hFFC, 0, q, e);
    check("unmapped err", e, 1);
    check("unmapped data", q, 0);
    for (int g = 0; g < 5; g++) xfer(1, 12'(`OFF_DIV0 + 4 * g), vals[g], q, e);
    for (int g = 0; g < 5; g++) xfer(1, 12'(`OFF_DLY0 + 4 * g), 15 - g, q, e);
    xfer(1, `OFF_ENABLE, 32'h1F, q, e);
    for (int g = 0; g < 5; g++) begin
      period(g, n);
      check("channel period", n, vals[g] == 0 ? 2 : 2 * vals[g]);
      check("delay steps", delay_steps[4 * g +: 4], 15 - g);
    end
    for (int m = 1; m >= 0; m--) begin
      xfer(1, `OFF_REFSEL, m, q, e);
      settle();
      check("fixed select", sel1, m);
      check("flag drive", {z_oe, o_oe}, 0);
    end
    xfer(1, `OFF_REFSEL, (`LOS_NMOS_OD << `REFSEL_DRV_LSB) | `REF_AUTO_A, q, e);
    stop0 <= 1;
    repeat (200) @(posedge pclk);
    xfer(0, `OFF_STATUS, 0, q, e);
    check("loss status", q, 32'h5);
    check("auto select", sel1, 1);
    check("irq masked", irq, 0);
    xfer(1, `OFF_MASK, 32'h1, q, e);
    settle();
    check("irq raised", irq, 1);
    stop0 <= 0;
    repeat (20) @(posedge pclk);
    xfer(1, `OFF_STATUS, 32'h7, q, e);
    settle();
    check("irq cleared", irq, 0);
    xfer(0, `OFF_STATUS, 0, q, e);
    check("status cleared", q, 0);
    complete_run();
  end
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule // tb_top
